/* src/dot_top.sv */
/*
  Output stage: frames each pair with timestamp, sequence number and the
  depth-mapping matrix, then streams invalid-coded disparities via a FIFO.
  Assumes the matcher supplies left-view disparities with an invalid flag
  and that frame starts are single-cycle pulses.
*/
`timescale 1ns/100ps
module dot_top (
  // Clock and reset
  input  wire logic                             clk_sys,
  input  wire logic                             resetn,
  // Configuration
  input  wire logic [1:0]                       sync_mode,
  input  wire logic                             ts_on_trigger,
  input  wire logic                             net_source,
  input  wire logic                             preview_open,
  input  wire logic [1:0]                       preview_session,
  input  wire logic                             ntp_load,
  input  wire logic [dot_pkg::TS_W-1:0]         ntp_time_us,
  // Trigger line 1 / sync input
  input  wire logic                             trig1_in,
  input  wire logic                             trig1_pulse,
  output logic                                  trig1_out,
  output logic                                  trig1_oe,
  // Frame events
  input  wire logic                             frame_arrived,
  input  wire logic [dot_pkg::TS_W-1:0]         net_ts,
  input  wire logic [dot_pkg::SEQ_W-1:0]        net_seq,
  // Depth-mapping matrix
  output logic      [3:0]                       q_index,
  input  wire logic [dot_pkg::QWORD_W-1:0]      q_word,
  // Disparity input
  input  wire logic                             pix_valid,
  output logic                                  pix_ready,
  input  wire logic [dot_pkg::DISP_W-1:0]       pix_disp,
  input  wire logic                             pix_bad,
  input  wire logic                             pix_last,
  // Result stream to the network side
  output logic                                  out_valid,
  input  wire logic                             out_ready,
  output logic      [dot_pkg::OUT_W-1:0]        out_data,
  // Raw preview
  output logic      [7:0]                       prev_pixel,
  output logic      [1:0]                       prev_session_r
);
  // Sync pin handling
  logic sync_d_r;
  logic [7:0] us_div_r;
  logic signed [dot_pkg::TS_W-1:0] clock_us_r;
  logic signed [dot_pkg::TS_W-1:0] latch_r;
  logic [dot_pkg::SEQ_W-1:0] seq_r;
  logic signed [dot_pkg::TS_W-1:0] ts_out_r;
  logic [dot_pkg::SEQ_W-1:0] seq_out_r;
  logic [3:0] q_cnt_r;
  dot_pkg::dot_state_t st_r;
  logic [7:0] prev_r;

  wire ext_sync  = (sync_mode == 2'(dot_pkg::SYNC_EXT));
  wire sync_edge = ext_sync && trig1_in && !sync_d_r;
  wire us_tick   = (us_div_r == dot_pkg::US_CYC_LAST);
  wire latch_ev  = ts_on_trigger ? trig1_pulse : frame_arrived;
  // Arrival stamp is the clock at this edge; latch_r still holds the previous frame's instant
  wire signed [dot_pkg::TS_W-1:0] ts_now = ts_on_trigger ? latch_r : clock_us_r;

  assign trig1_out = ext_sync ? 1'b0 : trig1_pulse;
  assign trig1_oe  = !ext_sync;

  // FIFO fill side
  logic f_valid;
  logic f_ready;
  logic [dot_pkg::OUT_W-1:0] f_data;
  wire in_hdr   = (st_r != dot_pkg::ST_IDLE) && (st_r != dot_pkg::ST_PIX);
  wire tx_allow = !preview_open;
  wire [11:0] disp_code = pix_bad ? dot_pkg::DISP_INVALID : pix_disp;

  always_comb begin
    f_valid = 1'b0;
    f_data  = '0;
    unique case (st_r)
      dot_pkg::ST_HDR_TS_HI: begin
        f_valid = 1'b1;
        f_data  = {dot_pkg::K_TS, ts_out_r[63:32]};
      end
      dot_pkg::ST_HDR_TS_LO: begin
        f_valid = 1'b1;
        f_data  = {dot_pkg::K_TS, ts_out_r[31:0]};
      end
      dot_pkg::ST_HDR_SEQ: begin
        f_valid = 1'b1;
        f_data  = {dot_pkg::K_SEQ, seq_out_r};
      end
      dot_pkg::ST_HDR_Q: begin
        f_valid = 1'b1;
        f_data  = {dot_pkg::K_Q, q_word};
      end
      dot_pkg::ST_PIX: begin
        f_valid = pix_valid && tx_allow;
        f_data  = {dot_pkg::K_PIX, 20'h00000, disp_code};
      end
      default: begin
        f_valid = 1'b0;
      end
    endcase
  end

  assign pix_ready = (st_r == dot_pkg::ST_PIX) && f_ready && tx_allow;
  assign q_index   = q_cnt_r;
  wire   hdr_go    = in_hdr && f_ready;
  wire   frame_go  = (st_r == dot_pkg::ST_IDLE) && frame_arrived && tx_allow;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_d_r   <= 1'b0;
      us_div_r   <= '0;
      clock_us_r <= '0;
    end else begin
      sync_d_r <= trig1_in;
      if (sync_edge) begin
        us_div_r   <= '0;
        clock_us_r <= '0;
      end else if (ntp_load && sync_mode == 2'(dot_pkg::SYNC_NTP)) begin
        us_div_r   <= '0;
        clock_us_r <= ntp_time_us;
      end else begin
        us_div_r <= us_tick ? 8'h00 : us_div_r + 8'h01;
        if (us_tick) clock_us_r <= clock_us_r + 64'sd1;
      end
    end
  end

  // Latched instant; a later sync edge shifts it below zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      latch_r <= '0;
    end else if (latch_ev) begin
      latch_r <= clock_us_r;
    end else if (sync_edge) begin
      latch_r <= latch_r - clock_us_r;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r      <= dot_pkg::ST_IDLE;
      seq_r     <= '0;
      ts_out_r  <= '0;
      seq_out_r <= '0;
      q_cnt_r   <= '0;
    end else begin
      unique case (st_r)
        dot_pkg::ST_IDLE: if (frame_go) begin
          st_r      <= dot_pkg::ST_HDR_TS_HI;
          ts_out_r  <= net_source ? net_ts : ts_now;
          seq_out_r <= net_source ? net_seq : seq_r;
          if (!net_source) seq_r <= seq_r + 32'h00000001;
        end
        dot_pkg::ST_HDR_TS_HI: if (hdr_go) st_r <= dot_pkg::ST_HDR_TS_LO;
        dot_pkg::ST_HDR_TS_LO: if (hdr_go) st_r <= dot_pkg::ST_HDR_SEQ;
        dot_pkg::ST_HDR_SEQ: if (hdr_go) begin
          st_r    <= dot_pkg::ST_HDR_Q;
          q_cnt_r <= '0;
        end
        dot_pkg::ST_HDR_Q: if (hdr_go) begin
          q_cnt_r <= q_cnt_r + 4'h1;
          if (q_cnt_r == 4'hF) st_r <= dot_pkg::ST_PIX;
        end
        dot_pkg::ST_PIX: if (pix_valid && pix_ready && pix_last) st_r <= dot_pkg::ST_IDLE;
      endcase
    end
  end

  // Raw preview: integer part, light gray for invalid
  wire [7:0] prev_nxt = pix_bad ? dot_pkg::PREV_GRAY : pix_disp[11:4];
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_r         <= '0;
      prev_session_r <= '0;
    end else begin
      if (pix_valid) prev_r <= prev_nxt;
      if (!preview_open) prev_session_r <= preview_session;
    end
  end
  assign prev_pixel = prev_r;

  dot_fifo #(.WIDTH(dot_pkg::OUT_W), .DEPTH(dot_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (f_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );
endmodule // dot_top

/* src/dot_pkg.sv */
/*
  Constants and types for the disparity output timestamper.
  Assumes a single 250 MHz clock and an upstream matcher that delivers
  left-viewpoint disparity pixels with an invalid flag.
*/
// Functional notes
// - Disparities are taken from the left camera's viewpoint and carry only a horizontal offset.
// - Each disparity word is 12 bits with 4 fractional bits, so the true value is the word over 16.
// - A pixel marked erroneous is sent as the all-ones code 0xFFF.
// - The calibration depth-mapping matrix is sent with every disparity map.
// - Each transmitted pair carries a timestamp field and a sequence number field.
// - The microsecond timestamp latches either the trigger instant or the frame arrival, by configuration.
// - For network-sourced images the supplied timestamp and sequence number pass through unchanged.
// - When locked to a time server, the clock counts microseconds since the 1970 epoch.
// - With no sync source the microsecond clock starts at zero at power-up.
// - With external sync selected, each rising sync edge clears the clock to zero.
// - A sync edge between latching and output makes the timestamp negative by the elapsed interval.
// - While the preview stream is open, transmission to other hosts halts and resumes when it ends; the code stops only new frames and pixels.
// - Only one browser streaming session receives data at a time.
// - Raw preview shows the integer disparity, and invalid pixels as light gray.
// - The first trigger output line can be turned into the sync input.
package dot_pkg;
  localparam int DISP_W      = 12;
  localparam int FRAC_W      = 4;
  localparam logic [11:0] DISP_INVALID = 12'hFFF;
  localparam int TS_W        = 64;
  localparam int SEQ_W       = 32;
  localparam int QWORD_W     = 32;
  localparam int Q_WORDS     = 16;
  localparam int CLK_MHZ     = 250;
  localparam int US_NS       = 1000;
  localparam int CLK_NS      = 4;
  localparam int US_CYC      = US_NS / CLK_NS;
  localparam logic [7:0] US_CYC_LAST = 8'(US_CYC - 1);
  localparam logic [7:0] PREV_GRAY   = 8'hC0;
  localparam int FIFO_DEPTH  = 16;
  localparam int OUT_W       = 2 + QWORD_W;
  localparam logic [1:0] K_PIX  = 2'h0;
  localparam logic [1:0] K_TS   = 2'h1;
  localparam logic [1:0] K_SEQ  = 2'h2;
  localparam logic [1:0] K_Q    = 2'h3;
  typedef enum logic [1:0] {SYNC_NONE, SYNC_EXT, SYNC_NTP} dot_sync_t;
  typedef enum {ST_IDLE, ST_HDR_TS_HI, ST_HDR_TS_LO, ST_HDR_SEQ, ST_HDR_Q, ST_PIX} dot_state_t;
endpackage

/* src/dot_fifo.sv */
/*
  Parameterised valid/ready FIFO.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module dot_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // dot_fifo

/* test/dot_assertions.sv */
/* Port checker for dot_top.
   Assumes one clock domain; bound below. */
`timescale 1ns/100ps
module dot_checker (
  // Inputs of the block
  input wire logic        clk_sys, resetn, preview_open, pix_valid, pix_bad, out_ready,
  input wire logic [1:0]  sync_mode, preview_session,
  input wire logic [11:0] pix_disp,
  // Outputs of the block
  input wire logic        pix_ready, out_valid, trig1_oe, trig1_out,
  input wire logic [1:0]  prev_session_r,
  input wire logic [7:0]  prev_pixel,
  input wire logic [33:0] out_data
);
  wire [7:0] disp_int = pix_disp[11:4];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence pix_take; pix_valid && pix_ready; endsequence
  chk_sync_pin_off: assert property (sync_mode == 2'h1 |-> !trig1_oe && !trig1_out)
    else $error("sync pin driven");
  chk_prev_gray: assert property (pix_take ##0 pix_bad |=> prev_pixel == dot_pkg::PREV_GRAY)
    else $error("bad pixel not gray");
  chk_prev_int: assert property (pix_take ##0 !pix_bad |=> prev_pixel == $past(disp_int))
    else $error("preview not integer part");
  chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("word changed while stalled");
  chk_preview_halt: assert property (preview_open |-> !pix_ready)
    else $error("pixel taken in preview");
  chk_session_take: assert property (!preview_open |=> prev_session_r == $past(preview_session))
    else $error("session not taken");
  chk_session_hold: assert property (preview_open [*2] |-> $stable(prev_session_r))
    else $error("session moved in preview");
  chk_pix_width: assert property (out_valid && out_data[33:32] == dot_pkg::K_PIX |-> out_data[31:12] == 20'h0)
    else $error("pixel word too wide");
endmodule // dot_checker

bind dot_top dot_checker u_chk (.clk_sys, .resetn, .preview_open, .pix_valid, .pix_bad, .out_ready, .sync_mode,
  .preview_session, .pix_disp, .pix_ready, .out_valid, .trig1_oe, .trig1_out, .prev_session_r, .prev_pixel, .out_data);

/* test/dot_client.sv */
/* Client model taking the result stream.
   Assumes the block's clock; stalls one cycle in four, or on hold. */
`timescale 1ns/100ps
module dot_client (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Stream
  input  wire logic        hold,
  input  wire logic        out_valid,
  input  wire logic [33:0] out_data,
  output logic             out_ready,
  // Taken words
  output logic             got,
  output logic      [33:0] got_data
);
  logic [1:0] cnt_r;
  assign out_ready = !hold && cnt_r != 2'h3;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 2'h0;
      got   <= 1'b0;
    end else begin
      cnt_r    <= cnt_r + 2'h1;
      got      <= out_valid && out_ready;
      got_data <= out_data;
    end
  end
endmodule // dot_client

/* test/test_dot_top.sv */
/* Bench for dot_top with the client model.
   Assumes the checker binds itself to the block. */
`timescale 1ns/100ps
module test_dot_top;
  logic clk_sys = 0, resetn = 0, ts_on_trigger = 0, net_source = 0, preview_open = 0, ntp_load = 0, sdrv = 0;
  logic trig1_pulse = 0, frame_arrived = 0, pix_valid = 0, pix_bad = 0, pix_last = 0, hold = 0, got;
  logic [1:0] sync_mode = 0, preview_session = 2'h2, prev_session_r;
  logic [63:0] ntp_time_us = 64'h0005A0B1C2D3E4F0, net_ts = 64'h0123456789ABCDEF;
  logic [31:0] net_seq = 32'h55AA1234, q_word;
  logic [11:0] pix_disp = 0;
  logic [3:0] q_index;
  logic [7:0] prev_pixel;
  logic pix_ready, out_valid, out_ready, trig1_out, trig1_oe;
  logic [33:0] out_data, got_data, w[$];
  // Pin level: the block when it drives, the sync source otherwise
  wire trig1_in = trig1_oe ? trig1_out : sdrv;
  int n_errors = 0, comparisons = 0;
  time t_rel;
  always #2 clk_sys = ~clk_sys;
  assign q_word = {28'hA5C3D7E, q_index};
  always @(posedge clk_sys) if (got) w.push_back(got_data);
  dot_top dut_u (.clk_sys, .resetn, .sync_mode, .ts_on_trigger, .net_source, .preview_open, .preview_session,
    .ntp_load, .ntp_time_us, .trig1_in, .trig1_pulse, .trig1_out, .trig1_oe, .frame_arrived, .net_ts, .net_seq,
    .q_index, .q_word, .pix_valid, .pix_ready, .pix_disp, .pix_bad, .pix_last, .out_valid, .out_ready, .out_data,
    .prev_pixel, .prev_session_r);
  dot_client cli_u (.clk_sys, .resetn, .hold, .out_valid, .out_data, .out_ready, .got, .got_data);
  task automatic check(input logic [63:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  function automatic logic [63:0] now_us();
    return 64'(($time - t_rel) / 1000);
  endfunction
  task automatic send_pix(input logic [11:0] d, input logic b, l);
    tick(1);
    {pix_valid, pix_disp, pix_bad, pix_last} = {1'b1, d, b, l};
    #1;
    while (!pix_ready) begin
      tick(1);
      #1;
    end
    @(posedge clk_sys);
  endtask
  task automatic t_frame(input string nm, input logic stall, input logic [63:0] lo, hi, input logic [31:0] sq);
    logic [63:0] ts;
    w.delete();
    hold = stall;
    frame_arrived = 1;
    tick(1);
    frame_arrived = 0;
    if (stall) begin
      // Header alone overfills the buffer
      tick(40);
      check(w.size(), 0);
      check(out_valid, 1);
      hold = 0;
    end
    send_pix(12'h000, 0, 0);
    send_pix(12'h7A5, 1, 0);
    send_pix(12'hFFE, 0, 1);
    tick(1);
    pix_valid = 0;
    for (int k = 0; k < 300 && w.size() < 22; k++) tick(1);
    tick(20);
    check(w.size(), 22);
    check(out_valid, 0);
    ts = {w[0][31:0], w[1][31:0]};
    check({w[0][33:32], w[1][33:32], w[2][33:32]}, 6'h16);
    check($signed(ts) >= $signed(lo) && $signed(ts) <= $signed(hi), 1);
    check(w[2][31:0], sq);
    for (int i = 0; i < 16; i++) check(w[3 + i], {2'h3, 28'hA5C3D7E, 4'(i)});
    check(w[19], 34'h0);
    check(w[20], 34'hFFF);
    check(w[21], 34'hFFE);
    $display("%s done", nm);
  endtask
  task automatic t_sync();
    ts_on_trigger = 1;
    trig1_pulse = 1;
    #1 check(trig1_out, 1);
    tick(1);
    sync_mode = 2'h1;
    #1 check(trig1_oe, 0);
    check(trig1_out, 0);
    tick(1);
    trig1_pulse = 0;
    tick(749);
    sdrv = 1;
    tick(500);
    t_frame("sync", 0, -64'sd4, -64'sd2, 2);
    sdrv = 0;
    ts_on_trigger = 0;
    sync_mode = 2'h2;
    ntp_load = 1;
    tick(1);
    ntp_load = 0;
    t_frame("server", 0, ntp_time_us, ntp_time_us + 2, 3);
  endtask
  task automatic t_preview();
    w.delete();
    preview_open = 1;
    tick(1);
    preview_session = 2'h1;
    frame_arrived = 1;
    tick(1);
    frame_arrived = 0;
    tick(40);
    check(w.size(), 0);
    check(prev_session_r, 2'h2);
    preview_open = 0;
    tick(3);
    check(prev_session_r, 2'h1);
    $display("preview done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    tick(8);
    resetn = 1;
    t_rel = $time;
    tick(1);
    check(trig1_oe, 1);
    t_frame("stalled", 1, now_us() - 1, now_us() + 2, 0);
    t_frame("camera", 0, now_us() - 1, now_us() + 2, 1);
    net_source = 1;
    t_frame("network", 0, net_ts, net_ts, net_seq);
    net_source = 0;
    t_sync();
    t_preview();
    end_sim();
  end
  initial begin
    repeat (8000) @(posedge clk_sys);
    n_errors++;
    end_sim();
  end
endmodule // test_dot_top
